// >>> rtl/ets_capture.v
// two-channel edge time stamp capture with shifting input image
`timescale 1ns/1ps
`default_nettype none
`include "ets_defs.vh"

module ets_capture #(
   parameter        LARGE_VARIANT = 0,
   parameter [17:0] DLY86_CYC     = `ETS_DLY86_US * `ETS_CLK_MHZ,
   parameter [17:0] DLY342_CYC    = `ETS_DLY342_US * `ETS_CLK_MHZ,
   parameter [17:0] DLY2731_CYC   = `ETS_DLY2731_US * `ETS_CLK_MHZ
) (
   // clock and reset
   input  wire        i_clk,
   input  wire        i_rst_n,
   // input pins
   input  wire        i_input_channel_zero,
   input  wire        i_input_channel_one,
   // microsecond ticker from head module
   input  wire [31:0] i_us_time,
   // parameter record port
   input  wire        i_prm_wr,
   input  wire [2:0]  i_prm_idx,
   input  wire [7:0]  i_prm_wdata,
   output wire [7:0]  o_prm_rdata,
   // input process image port
   input  wire [5:0]  i_img_addr,
   input  wire        i_img_hold,
   output wire [7:0]  o_img_rdata,
   // status
   output wire [3:0]  o_entry_count,
   output wire        o_capture_ready,
   output wire [1:0]  o_input_state
);

   // ---------------------------------------------------------------
   // variant constants
   // ---------------------------------------------------------------
   // image depth and input length for the selected variant
   localparam [3:0] DEPTH  = LARGE_VARIANT ? `ETS_ENTRIES_LARGE : `ETS_ENTRIES_SMALL;
   localparam [7:0] IN_LEN = LARGE_VARIANT ? `ETS_IN_LEN_LARGE : `ETS_IN_LEN_SMALL;
   localparam [17:0] DLY1_CYC  = `ETS_DLY1_US * `ETS_CLK_MHZ;
   localparam [17:0] DLY3_CYC  = `ETS_DLY3_US * `ETS_CLK_MHZ;
   localparam [17:0] DLY10_CYC = `ETS_DLY10_US * `ETS_CLK_MHZ;

   // ---------------------------------------------------------------
   // parameter registers
   // ---------------------------------------------------------------
   reg [7:0] dly0_reg;
   reg [7:0] dly1_reg;
   reg [7:0] rise_reg;
   reg [7:0] fall_reg;
   reg [7:0] prm_rdata;

   function legal_code;
      input [7:0] code;
      begin
         legal_code = (code == `ETS_DCODE_1)   || (code == `ETS_DCODE_3) ||
                      (code == `ETS_DCODE_10)  || (code == `ETS_DCODE_86) ||
                      (code == `ETS_DCODE_342) || (code == `ETS_DCODE_2731);
      end
   endfunction

   function [17:0] code_limit;
      input [7:0] code;
      begin
         case (code)
            `ETS_DCODE_1:    code_limit = DLY1_CYC;
            `ETS_DCODE_3:    code_limit = DLY3_CYC;
            `ETS_DCODE_10:   code_limit = DLY10_CYC;
            `ETS_DCODE_86:   code_limit = DLY86_CYC;
            `ETS_DCODE_342:  code_limit = DLY342_CYC;
            `ETS_DCODE_2731: code_limit = DLY2731_CYC;
            default:         code_limit = DLY3_CYC;
         endcase
      end
   endfunction

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         dly0_reg <= `ETS_DLY_RST;
         dly1_reg <= `ETS_DLY_RST;
         rise_reg <= `ETS_EDGE_RST;
         fall_reg <= `ETS_EDGE_RST;
      end else if (i_prm_wr) begin
         case (i_prm_idx)
            `ETS_IDX_DLY0: begin
               if (legal_code(i_prm_wdata)) begin
                  dly0_reg <= i_prm_wdata;
               end
            end
            `ETS_IDX_DLY1: begin
               if (legal_code(i_prm_wdata)) begin
                  dly1_reg <= i_prm_wdata;
               end
            end
            `ETS_IDX_RISE: begin
               rise_reg <= i_prm_wdata & `ETS_EDGE_MASK;
            end
            `ETS_IDX_FALL: begin
               fall_reg <= i_prm_wdata & `ETS_EDGE_MASK;
            end
            default: begin
            end
         endcase
      end
   end

   always @* begin
      case (i_prm_idx)
         `ETS_IDX_IN_LEN:  prm_rdata = IN_LEN;
         `ETS_IDX_OUT_LEN: prm_rdata = `ETS_OUT_LEN;
         `ETS_IDX_DLY0:    prm_rdata = dly0_reg;
         `ETS_IDX_DLY1:    prm_rdata = dly1_reg;
         `ETS_IDX_RISE:    prm_rdata = rise_reg;
         `ETS_IDX_FALL:    prm_rdata = fall_reg;
         default:          prm_rdata = 8'h00;
      endcase
   end

   assign o_prm_rdata = prm_rdata;

   // ---------------------------------------------------------------
   // input filters and edge detection
   // ---------------------------------------------------------------
   wire [1:0]  pins  = {i_input_channel_one, i_input_channel_zero};
   wire [35:0] limits = {code_limit(dly1_reg), code_limit(dly0_reg)};
   wire [1:0]  level;
   reg  [1:0]  prev_reg;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_chan
         ets_filter u_filter (
            .i_clk   (i_clk),
            .i_rst_n (i_rst_n),
            .i_pin   (pins[g]),
            .i_limit (limits[g*18 +: 18]),
            .o_level (level[g])
         );
      end
   endgenerate

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         prev_reg <= 2'h0;
      end else begin
         prev_reg <= level;
      end
   end

   wire [1:0] rise_ev = level & ~prev_reg & rise_reg[1:0];
   wire [1:0] fall_ev = ~level & prev_reg & fall_reg[1:0];
   wire       event_any = |(rise_ev | fall_ev);
   wire [31:0] new_entry = {level, i_us_time[`ETS_STATE_LSB-1:0]};

   // ---------------------------------------------------------------
   // two-entry buffer
   // ---------------------------------------------------------------
   reg [31:0] buf_reg [0:1];
   reg        wr_ptr_reg;
   reg        rd_ptr_reg;
   reg [1:0]  buf_cnt_reg;
   wire       buf_in_ready  = (buf_cnt_reg != 2'h2);
   wire       buf_out_valid = (buf_cnt_reg != 2'h0);
   wire       buf_out_ready = ~i_img_hold;
   wire       buf_push      = event_any & buf_in_ready;
   wire       buf_pop       = buf_out_valid & buf_out_ready;

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         wr_ptr_reg  <= 1'b0;
         rd_ptr_reg  <= 1'b0;
         buf_cnt_reg <= 2'h0;
         buf_reg[0]  <= 32'h00000000;
         buf_reg[1]  <= 32'h00000000;
      end else begin
         if (buf_push) begin
            buf_reg[wr_ptr_reg] <= new_entry;
            wr_ptr_reg          <= ~wr_ptr_reg;
         end
         if (buf_pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         case ({buf_push, buf_pop})
            2'b10:   buf_cnt_reg <= buf_cnt_reg + 2'h1;
            2'b01:   buf_cnt_reg <= buf_cnt_reg - 2'h1;
            default: buf_cnt_reg <= buf_cnt_reg;
         endcase
      end
   end

   assign o_capture_ready = buf_in_ready;

   // ---------------------------------------------------------------
   // input process image
   // ---------------------------------------------------------------
   reg [31:0] img_reg [0:14];
   reg [3:0]  count_reg;

   generate
      for (g = 0; g < 15; g = g + 1) begin : g_img
         always @(posedge i_clk) begin
            if (!i_rst_n) begin
               img_reg[g] <= 32'h00000000;
            end else if (buf_pop) begin
               if (g == 0) begin
                  img_reg[g] <= buf_reg[rd_ptr_reg];
               end else begin
                  img_reg[g] <= img_reg[(g > 0) ? g - 1 : 0];
               end
            end
         end
      end
   endgenerate

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         count_reg <= 4'h0;
      end else if (buf_pop && count_reg != DEPTH) begin
         count_reg <= count_reg + 4'h1;
      end
   end

   // ---------------------------------------------------------------
   // image read
   // ---------------------------------------------------------------
   reg  [7:0]  img_rdata_reg;
   wire [3:0]  rd_entry = i_img_addr[5:2];
   wire [31:0] rd_word  = img_reg[rd_entry];

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         img_rdata_reg <= 8'h00;
      end else if (rd_entry >= DEPTH) begin
         img_rdata_reg <= 8'h00;
      end else begin
         img_rdata_reg <= rd_word[i_img_addr[1:0]*8 +: 8];
      end
   end

   assign o_img_rdata   = img_rdata_reg;
   assign o_entry_count = count_reg;
   assign o_input_state = prev_reg;

endmodule // ets_capture

`default_nettype wire

// >>> rtl/ets_defs.vh
// constants shared by the edge time stamp capture block
`ifndef ETS_DEFS_VH
`define ETS_DEFS_VH

// ---------------------------------------------------------------
// parameter byte indices
// ---------------------------------------------------------------
`define ETS_IDX_IN_LEN    3'h0
`define ETS_IDX_OUT_LEN   3'h1
`define ETS_IDX_DLY0      3'h2
`define ETS_IDX_DLY1      3'h3
`define ETS_IDX_RISE      3'h4
`define ETS_IDX_FALL      3'h5

// ---------------------------------------------------------------
// fixed and reset values
// ---------------------------------------------------------------
`define ETS_IN_LEN_SMALL  8'h14
`define ETS_IN_LEN_LARGE  8'h3c
`define ETS_OUT_LEN       8'h00
`define ETS_DLY_RST       8'h02
`define ETS_EDGE_RST      8'h00
`define ETS_EDGE_MASK     8'h03
`define ETS_ENTRIES_SMALL 4'h5
`define ETS_ENTRIES_LARGE 4'hf
`define ETS_STATE_LSB     30

// ---------------------------------------------------------------
// delay codes and their times
// ---------------------------------------------------------------
`define ETS_DCODE_1       8'h00
`define ETS_DCODE_3       8'h02
`define ETS_DCODE_10      8'h04
`define ETS_DCODE_86      8'h07
`define ETS_DCODE_342     8'h09
`define ETS_DCODE_2731    8'h0c
`define ETS_DLY1_US       1
`define ETS_DLY3_US       3
`define ETS_DLY10_US      10
`define ETS_DLY86_US      86
`define ETS_DLY342_US     342
`define ETS_DLY2731_US    2731
`define ETS_CLK_MHZ       50

`endif

// >>> rtl/ets_filter.v
// input synchroniser and delay filter for one channel
`timescale 1ns/1ps
`default_nettype none

module ets_filter (
   // clock and reset
   input  wire        i_clk,
   input  wire        i_rst_n,
   // pin and setting
   input  wire        i_pin,
   input  wire [17:0] i_limit,
   // filtered level
   output wire        o_level
);

   reg        sync1_reg;
   reg        sync2_reg;
   reg [17:0] cnt_reg;
   reg        level_reg;
   wire [17:0] cnt_inc = cnt_reg + 18'h00001;

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         cnt_reg   <= 18'h00000;
         level_reg <= 1'b0;
      end else begin
         sync1_reg <= i_pin;
         sync2_reg <= sync1_reg;
         if (sync2_reg == level_reg) begin
            cnt_reg <= 18'h00000;
         end else if (cnt_inc >= i_limit) begin
            cnt_reg   <= 18'h00000;
            level_reg <= sync2_reg;
         end else begin
            cnt_reg <= cnt_inc;
         end
      end
   end

   assign o_level = level_reg;

endmodule // ets_filter

`default_nettype wire

// >>> tb/ets_checker.sv
// port assertions for the edge time stamp capture block
`timescale 1ns/1ps
`default_nettype none
module ets_checker #(
   parameter LARGE_VARIANT = 0
) (
   input wire logic       i_clk,
   input wire logic       i_rst_n,
   input wire logic       i_prm_wr,
   input wire logic [2:0] i_prm_idx,
   input wire logic [7:0] i_prm_wdata,
   input wire logic [7:0] o_prm_rdata,
   input wire logic [5:0] i_img_addr,
   input wire logic       i_img_hold,
   input wire logic [7:0] o_img_rdata,
   input wire logic [3:0] o_entry_count
);
   localparam logic [7:0] LEN = LARGE_VARIANT ? 8'h3c : 8'h14;
   localparam logic [3:0] MAXE = LARGE_VARIANT ? 4'hf : 4'h5;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_rise_wr;
      i_prm_wr && i_prm_idx == 3'h4;
   endsequence
   a_in_len: assert property (i_prm_idx == 3'h0 |-> o_prm_rdata == LEN)
      else $error("input length byte wrong");
   a_out_len: assert property (i_prm_idx == 3'h1 |-> o_prm_rdata == 8'h00)
      else $error("output length byte not zero");
   a_dly_legal: assert property (i_prm_idx inside {3'h2, 3'h3} |->
      o_prm_rdata inside {8'h00, 8'h02, 8'h04, 8'h07, 8'h09, 8'h0c})
      else $error("delay code outside legal set");
   a_rise_readback: assert property (s_rise_wr |=>
      i_prm_idx != 3'h4 || o_prm_rdata == {6'h00, $past(i_prm_wdata[1:0])})
      else $error("rising enable readback wrong");
   a_count_max: assert property (o_entry_count <= MAXE)
      else $error("entry count above image size");
   a_count_step: assert property ($past(i_rst_n) |->
      o_entry_count == $past(o_entry_count) || o_entry_count == $past(o_entry_count) + 4'h1)
      else $error("entry count jumped");
   a_hold_freeze: assert property (i_img_hold |=> $stable(o_entry_count))
      else $error("image moved while held");
   a_img_oob: assert property ({2'b00, i_img_addr} >= LEN |=> o_img_rdata == 8'h00)
      else $error("byte beyond image not zero");
endmodule // ets_checker
bind ets_capture ets_checker #(.LARGE_VARIANT(LARGE_VARIANT)) CHK (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_prm_wr(i_prm_wr), .i_prm_idx(i_prm_idx),
   .i_prm_wdata(i_prm_wdata), .o_prm_rdata(o_prm_rdata), .i_img_addr(i_img_addr),
   .i_img_hold(i_img_hold), .o_img_rdata(o_img_rdata), .o_entry_count(o_entry_count));
`default_nettype wire

// >>> tb/ets_head_model.sv
// head module model: microsecond ticker and image reader
`timescale 1ns/1ps
`default_nettype none
module ets_head_model (
   input  wire logic        i_clk,
   input  wire logic [7:0]  i_img_rdata,
   output var  logic [31:0] o_us_time,
   output var  logic [5:0]  o_img_addr,
   output var  logic        o_img_hold
);
   int div = 0;
   // top bits set so a time leaking into the state bits shows
   initial begin
      o_us_time = 32'hc000_0100;
      o_img_addr = 6'h00;
      o_img_hold = 1'b0;
   end
   always @(posedge i_clk) begin
      div <= (div == 49) ? 0 : div + 1;
      if (div == 49)
         o_us_time <= o_us_time + 32'h1;
   end
   task automatic hold(input logic h);
      @(posedge i_clk) #1 o_img_hold = h;
   endtask
   task automatic rd(input int k, output logic [31:0] d);
      for (int b = 0; b < 4; b++) begin
         @(posedge i_clk) #1 o_img_addr = 6'(4 * k + b);
         @(posedge i_clk) #1 d[8*b+:8] = i_img_rdata;
      end
   endtask
endmodule // ets_head_model
`default_nettype wire

// >>> tb/ets_capture_bench.sv
// self-checking testbench for the edge time stamp capture block
`timescale 1ns/1ps
`default_nettype none
module ets_capture_bench;
   logic        i_clk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic [1:0]  pin = 2'b00;
   logic        prm_wr = 1'b0;
   logic [2:0]  prm_idx = 3'h0;
   logic [7:0]  prm_wdata = 8'h00;
   logic [7:0]  prm_rdata, img_rdata;
   logic [31:0] us_time;
   logic [5:0]  img_addr;
   logic        img_hold, cap_ready;
   logic [3:0]  entry_count;
   logic [1:0]  in_state;
   logic [7:0]  prm_rdata_l;
   logic [3:0]  entry_count_l;
   int          error_cnt = 0;
   int          checks_done = 0;
   logic [1:0]  exp_st[$];
   logic [29:0] exp_t[$];
   ets_capture DUT (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_input_channel_zero(pin[0]), .i_input_channel_one(pin[1]),
      .i_us_time(us_time), .i_prm_wr(prm_wr), .i_prm_idx(prm_idx), .i_prm_wdata(prm_wdata),
      .o_prm_rdata(prm_rdata), .i_img_addr(img_addr), .i_img_hold(img_hold), .o_img_rdata(img_rdata),
      .o_entry_count(entry_count), .o_capture_ready(cap_ready), .o_input_state(in_state));
   ets_head_model HEAD (.i_clk(i_clk), .i_img_rdata(img_rdata), .o_us_time(us_time),
      .o_img_addr(img_addr), .o_img_hold(img_hold));
   ets_capture #(.LARGE_VARIANT(1)) DUT_LARGE (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_input_channel_zero(pin[0]), .i_input_channel_one(pin[1]),
      .i_us_time(us_time), .i_prm_wr(prm_wr), .i_prm_idx(prm_idx), .i_prm_wdata(prm_wdata),
      .o_prm_rdata(prm_rdata_l), .i_img_addr(img_addr), .i_img_hold(img_hold), .o_img_rdata(),
      .o_entry_count(entry_count_l), .o_capture_ready(), .o_input_state());
   initial forever #10 i_clk = ~i_clk;
   task automatic stop_test;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_win(input logic [29:0] got, input logic [29:0] lo);
      checks_done++;
      if (!((got >= lo) === 1'b1 && (got <= lo + 30'h2) === 1'b1)) begin
         error_cnt++;
         $display("Error at %0t: time %h not near %h", $time, got, lo);
      end
   endtask
   task automatic wr(input logic [2:0] idx, input logic [7:0] d);
      @(posedge i_clk) #1 prm_wr = 1'b1;
      prm_idx = idx;
      prm_wdata = d;
      @(posedge i_clk) #1 prm_wr = 1'b0;
   endtask
   task automatic rdp(input logic [2:0] idx, input logic [7:0] exp);
      @(posedge i_clk) #1 prm_idx = idx;
      #1 chk({24'h0, prm_rdata}, {24'h0, exp});
   endtask
   // a filtered edge at 1 us needs about 54 cycles to reach the image
   task automatic step_pin(input logic [1:0] v, input bit rec);
      @(posedge i_clk) #1 pin = v;
      if (rec) begin
         exp_st.push_front(v);
         exp_t.push_front(us_time[29:0]);
      end
      if (exp_st.size() > 5) begin
         exp_st.pop_back();
         exp_t.pop_back();
      end
      repeat (70) @(posedge i_clk);
      #1 chk({30'h0, in_state}, {30'h0, v});
   endtask
   task automatic chk_img;
      logic [31:0] d;
      chk({28'h0, entry_count}, {28'h0, 4'(exp_st.size())});
      foreach (exp_st[k]) begin
         HEAD.rd(k, d);
         chk({30'h0, d[31:30]}, {30'h0, exp_st[k]});
         chk_win(d[29:0], exp_t[k]);
      end
      HEAD.rd(5, d);
      chk(d, 32'h0);
   endtask
   task automatic t_regs;
      logic [7:0] rv[8] = '{8'h14, 8'h00, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
      logic [7:0] cd[6] = '{8'h00, 8'h02, 8'h04, 8'h07, 8'h09, 8'h0c};
      for (int i = 0; i < 8; i++)
         rdp(3'(i), rv[i]);
      wr(3'h0, 8'hff);
      wr(3'h1, 8'hff);
      rdp(3'h0, 8'h14);
      chk({24'h0, prm_rdata_l}, 32'h3c);
      rdp(3'h1, 8'h00);
      foreach (cd[i]) begin
         wr(3'h2, cd[i]);
         wr(3'h3, cd[i]);
         rdp(3'h2, cd[i]);
         rdp(3'h3, cd[i]);
      end
      wr(3'h2, 8'h01);
      rdp(3'h2, 8'h0c);
      wr(3'h4, 8'hff);
      rdp(3'h4, 8'h03);
      wr(3'h5, 8'hfe);
      rdp(3'h5, 8'h02);
      wr(3'h2, 8'h00);
      wr(3'h3, 8'h00);
      wr(3'h4, 8'h01);
   endtask
   // short pulses must not pass the filter, also at the 3 us code
   task automatic t_peak;
      @(posedge i_clk) #1 pin = 2'b01;
      repeat (20) @(posedge i_clk);
      #1 pin = 2'b00;
      wr(3'h2, 8'h02);
      @(posedge i_clk) #1 pin = 2'b01;
      repeat (100) @(posedge i_clk);
      #1 pin = 2'b00;
      repeat (70) @(posedge i_clk);
      #1 chk({28'h0, entry_count}, 32'h0);
      chk({30'h0, in_state}, 32'h0);
      wr(3'h2, 8'h00);
   endtask
   task automatic t_capture;
      step_pin(2'b01, 1'b1);
      step_pin(2'b11, 1'b0);
      step_pin(2'b01, 1'b1);
      step_pin(2'b00, 1'b0);
      chk_img;
   endtask
   task automatic t_same;
      wr(3'h4, 8'h03);
      wr(3'h5, 8'h03);
      step_pin(2'b11, 1'b1);
      step_pin(2'b00, 1'b1);
      chk_img;
   endtask
   task automatic t_overflow;
      step_pin(2'b01, 1'b1);
      step_pin(2'b00, 1'b1);
      step_pin(2'b10, 1'b1);
      chk_img;
   endtask
   task automatic t_hold;
      HEAD.hold(1'b1);
      step_pin(2'b11, 1'b1);
      step_pin(2'b01, 1'b1);
      chk({31'h0, cap_ready}, 32'h0);
      step_pin(2'b00, 1'b0);
      chk({28'h0, entry_count}, 32'h5);
      HEAD.hold(1'b0);
      repeat (4) @(posedge i_clk);
      #1 chk({31'h0, cap_ready}, 32'h1);
      chk_img;
      chk({28'h0, entry_count_l}, 32'h9);
   endtask
   initial begin
      repeat (20) @(posedge i_clk);
      #1 i_rst_n = 1'b1;
      t_regs;
      t_peak;
      t_capture;
      t_same;
      t_overflow;
      t_hold;
      stop_test;
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      error_cnt++;
      $display("Error at %0t: run too long", $time);
      stop_test;
   end
endmodule // ets_capture_bench
`default_nettype wire
